//--- logic/scc_cdb_checker.v
// Function
// - byte zero of every command is the operation code
// - all mandatory operation codes are accepted via the supported table
// - nonzero reserved bits or reserved codes reject with illegal request
// - reserved bits and reserved codes may be accepted when an extension enable says so
// - supported optional commands pass decode unchanged; unsupported ones reject
// - last byte of every block is the control byte
// - invalid blocks are rejected before any medium change is allowed
// - parameter list follows in data out; flagged for the executor
// - six-byte layout: opcode, unit and address, address, length, control
// - ten-byte layout: address bytes 2-5, reserved 6, length 7-8, control 9
// - twelve-byte layout: unit high bits, address 2-5, length 6-9, control 11
// - block length comes from the operation code group bits
// - address is 21 bits for six-byte blocks, 32 bits otherwise
// - one-byte length zero means 256; multi-byte zero means none
// - unit field ignored when identify already selected the unit
`timescale 1ns/1ps
`include "scc_consts.vh"
module scc_cdb_checker #(
	parameter [255:0] SUPPORTED = {256{1'b1}},
	parameter [255:0] PARAM_LIST = {256{1'b0}},
	parameter VENDOR_LEN = 4'hA
)
(
	// clock and reset
	input wire clock,
	input wire reset_n,
	// command bytes from the bus phase logic
	input wire byte_valid,
	input wire [7:0] byte_data,
	input wire cmd_start,
	// nexus and options
	input wire identify_seen,
	input wire [2:0] identify_lun,
	input wire ext_reserved_ok,
	input wire link_supported,
	// decoded command
	output reg done_q,
	output reg accept_q,
	output reg reject_q,
	output reg [3:0] sense_key_q,
	output reg [2:0] reason_q,
	output reg [7:0] opcode_q,
	output reg [2:0] lun_q,
	output reg [31:0] lba_q,
	output reg [31:0] xfer_len_q,
	output reg [7:0] control_q,
	output reg data_out_q,
	output reg [3:0] cdb_len_q
);
	reg [7:0] cdb_q [0:11];
	reg [3:0] idx_q;
	reg [3:0] len_q;
	reg busy_q;
	reg grp_res_q;
	reg grp_ven_q;
	wire [3:0] len_c;
	wire res_c;
	wire ven_c;
	reg bad_res;
	reg [2:0] rsn;
	reg [31:0] lba_c;
	reg [31:0] xl_c;
	reg [2:0] lun_c;
	reg [7:0] ctl;
	wire [11:0] wr_sel;
	genvar e;

	scc_opcode_class u_class
	(
		.opcode(byte_data),
		.cdb_len(len_c),
		.grp_reserved(res_c),
		.grp_vendor(ven_c)
	);

	wire last = busy_q && byte_valid && (idx_q == len_q - 4'h1);

	assign wr_sel = 12'h001 << idx_q;

	// one flip-flop byte per block position; an index past the last entry selects none
	generate
		for (e = 0; e < 12; e = e + 1)
		begin : g_byte
			always @(posedge clock)
			begin
				if (!reset_n)
				begin
					cdb_q[e] <= `SCC_RST_BYTE;
				end
				else if (!cmd_start && busy_q && byte_valid && wr_sel[e])
				begin
					cdb_q[e] <= byte_data;
				end
			end
		end
	endgenerate

	// field extraction and checks on the full block, byte_data is the control byte
	always @*
	begin
		ctl = byte_data;
		bad_res = 1'b0;
		lba_c = 32'h0;
		xl_c = 32'h0;
		lun_c = cdb_q[1][7:5];
		case (len_q)
			`SCC_LEN6:
			begin
				lba_c = {11'h0, cdb_q[1][4:0], cdb_q[2], cdb_q[3]};
				xl_c = (cdb_q[4] == 8'h00) ? 32'h100 : {24'h0, cdb_q[4]};
			end
			`SCC_LEN10:
			begin
				lba_c = {cdb_q[2], cdb_q[3], cdb_q[4], cdb_q[5]};
				xl_c = {16'h0, cdb_q[7], cdb_q[8]};
				bad_res = (cdb_q[`SCC_B_RSV10] != 8'h00);
			end
			`SCC_LEN12:
			begin
				lba_c = {cdb_q[2], cdb_q[3], cdb_q[4], cdb_q[5]};
				xl_c = {cdb_q[6], cdb_q[7], cdb_q[8], cdb_q[9]};
				bad_res = (cdb_q[1][4:0] != 5'h00) || (cdb_q[`SCC_B_RSV12] != 8'h00);
			end
			default:
			begin
				lba_c = 32'h0;
			end
		endcase
		if (grp_ven_q)
		begin
			bad_res = 1'b0;
		end
		bad_res = bad_res || ((ctl & `SCC_CTL_RSV_MASK) != 8'h00);
		if (ext_reserved_ok)
		begin
			bad_res = 1'b0;
		end
		if (identify_seen)
		begin
			lun_c = identify_lun;
		end
		rsn = `SCC_RSN_NONE;
		if (grp_res_q && !ext_reserved_ok)
		begin
			rsn = `SCC_RSN_OPCODE;
		end
		else if (!SUPPORTED[cdb_q[0]])
		begin
			rsn = `SCC_RSN_UNSUPPORTED;
		end
		else if (bad_res)
		begin
			rsn = `SCC_RSN_RESERVED;
		end
		else if ((ctl[`SCC_CTL_FLAG] && !ctl[`SCC_CTL_LINK])
			|| ((ctl[`SCC_CTL_FLAG] || ctl[`SCC_CTL_LINK]) && !link_supported))
		begin
			rsn = `SCC_RSN_CONTROL;
		end
	end

	always @(posedge clock)
	begin
		if (!reset_n)
		begin
			idx_q <= 4'h0;
			len_q <= `SCC_LEN6;
			busy_q <= 1'b0;
			grp_res_q <= 1'b0;
			grp_ven_q <= 1'b0;
			done_q <= 1'b0;
			accept_q <= 1'b0;
			reject_q <= 1'b0;
			sense_key_q <= 4'h0;
			reason_q <= `SCC_RSN_NONE;
			opcode_q <= `SCC_RST_BYTE;
			lun_q <= 3'h0;
			lba_q <= 32'h0;
			xfer_len_q <= 32'h0;
			control_q <= `SCC_RST_BYTE;
			data_out_q <= 1'b0;
			cdb_len_q <= 4'h0;
		end
		else
		begin
			done_q <= 1'b0;
			accept_q <= 1'b0;
			reject_q <= 1'b0;
			if (cmd_start)
			begin
				busy_q <= 1'b1;
				idx_q <= 4'h0;
			end
			else if (busy_q && byte_valid)
			begin
				idx_q <= idx_q + 4'h1;
				if (idx_q == `SCC_B_OPC)
				begin
					len_q <= ven_c ? VENDOR_LEN : (res_c ? `SCC_LEN6 : len_c);
					grp_res_q <= res_c;
					grp_ven_q <= ven_c;
				end
				if (last)
				begin
					// executor sees accept only when every check passed
					busy_q <= 1'b0;
					done_q <= 1'b1;
					accept_q <= (rsn == `SCC_RSN_NONE);
					reject_q <= (rsn != `SCC_RSN_NONE);
					sense_key_q <= (rsn != `SCC_RSN_NONE) ? `SCC_SENSE_ILLEGAL : 4'h0;
					reason_q <= rsn;
					opcode_q <= cdb_q[0];
					lun_q <= lun_c;
					lba_q <= lba_c;
					xfer_len_q <= xl_c;
					control_q <= ctl;
					data_out_q <= PARAM_LIST[cdb_q[0]] && (rsn == `SCC_RSN_NONE);
					cdb_len_q <= len_q;
				end
			end
		end
	end
endmodule // scc_cdb_checker

//--- shared/scc_consts.vh
`ifndef SCC_CONSTS_VH
`define SCC_CONSTS_VH
// group code field of the operation code
`define SCC_GRP_HI 7
`define SCC_GRP_LO 5
// block lengths in bytes
`define SCC_LEN6 4'h6
`define SCC_LEN10 4'hA
`define SCC_LEN12 4'hC
// byte positions of fields
`define SCC_B_OPC 4'h0
`define SCC_B_LUN 4'h1
`define SCC_B_RSV10 4'h6
`define SCC_B_RSV12 4'hA
// control byte reserved field (bits 5..2), flag bit 1, link bit 0
`define SCC_CTL_RSV_MASK 8'h3C
`define SCC_CTL_FLAG 1
`define SCC_CTL_LINK 0
// sense key for rejected commands
`define SCC_SENSE_ILLEGAL 4'h5
// reject reasons
`define SCC_RSN_NONE 3'h0
`define SCC_RSN_OPCODE 3'h1
`define SCC_RSN_RESERVED 3'h2
`define SCC_RSN_CONTROL 3'h3
`define SCC_RSN_UNSUPPORTED 3'h4
// reset values
`define SCC_RST_BYTE 8'h00
`endif

//--- logic/scc_opcode_class.v
`timescale 1ns/1ps
`include "scc_consts.vh"
module scc_opcode_class
(
	// operation code in
	input wire [7:0] opcode,
	// classification out
	output reg [3:0] cdb_len,
	output reg grp_reserved,
	output reg grp_vendor
);
	always @*
	begin
		cdb_len = `SCC_LEN6;
		grp_reserved = 1'b0;
		grp_vendor = 1'b0;
		case (opcode[`SCC_GRP_HI:`SCC_GRP_LO])
			3'h0: cdb_len = `SCC_LEN6;
			3'h1, 3'h2: cdb_len = `SCC_LEN10;
			3'h5: cdb_len = `SCC_LEN12;
			3'h3, 3'h4: grp_reserved = 1'b1;
			default: grp_vendor = 1'b1;
		endcase
	end
endmodule // scc_opcode_class

//--- verification/scc_cdb_checker_asserts.sv
`timescale 1ns/1ps
module scc_cdb_checker_asserts
(
	input wire clock,
	input wire reset_n,
	input wire byte_valid,
	input wire identify_seen,
	input wire [2:0] identify_lun,
	input wire done_q,
	input wire accept_q,
	input wire reject_q,
	input wire [3:0] sense_key_q,
	input wire [2:0] reason_q,
	input wire [2:0] lun_q,
	input wire [31:0] xfer_len_q,
	input wire [3:0] cdb_len_q
);
	default clocking @(posedge clock);
	endclocking
	default disable iff (!reset_n);
	AST_ONE_VERDICT: assert property (done_q |-> accept_q ^ reject_q)
		else $error("verdict not one-hot");
	AST_NO_STRAY: assert property (!done_q |-> !accept_q && !reject_q)
		else $error("verdict without done");
	AST_DONE_PULSE: assert property (done_q |=> !done_q)
		else $error("done longer than one cycle");
	AST_AFTER_BYTE: assert property (done_q |-> $past(byte_valid))
		else $error("done not after last byte");
	AST_REJ_SENSE: assert property (reject_q |-> sense_key_q == 4'h5)
		else $error("reject without illegal request");
	AST_ACC_CLEAN: assert property (accept_q |-> sense_key_q == 4'h0 && reason_q == 3'h0)
		else $error("accept with error code");
	AST_UNIT: assert property (done_q && $past(identify_seen) |->
		lun_q == $past(identify_lun)) else $error("unit not from identify");
	AST_SHORT_LEN: assert property (done_q && cdb_len_q == 4'h6 |-> xfer_len_q != 0)
		else $error("short length zero");
endmodule // scc_cdb_checker_asserts
bind scc_cdb_checker scc_cdb_checker_asserts i_asserts (.*);

//--- verification/scc_init_model.sv
`timescale 1ns/1ps
module scc_init_model
(
	input wire clock,
	output reg cmd_start,
	output reg byte_valid,
	output reg [7:0] byte_data
);
	initial {cmd_start, byte_valid, byte_data} = 10'h000;
	// one block: start pulse, then bytes, optionally with idle cycles between
	task send(input logic [7:0] b [12], input int n, input int gap);
		@(negedge clock) cmd_start = 1;
		for (int i = 0; i < n; i++)
		begin
			@(negedge clock) cmd_start = 0;
			byte_valid = 1;
			byte_data = b[i];
			if (gap && i < n - 1)
			begin
				@(negedge clock) byte_valid = 0;
				byte_data = ~b[i];
			end
		end
		@(negedge clock) byte_valid = 0;
		byte_data = ~byte_data;
	endtask
endmodule // scc_init_model

//--- verification/scc_cdb_checker_test.sv
`timescale 1ns/1ps
module scc_cdb_checker_test;
	reg clock = 0;
	reg reset_n = 0;
	reg identify_seen = 0;
	reg [2:0] identify_lun = 0;
	reg ext_reserved_ok = 0;
	reg link_supported = 0;
	wire cmd_start, byte_valid, done_q, accept_q, reject_q, data_out_q;
	wire [7:0] byte_data, opcode_q, control_q;
	wire [2:0] reason_q, lun_q;
	wire [3:0] cdb_len_q, sense_key_q;
	wire [31:0] lba_q, xfer_len_q;
	logic [91:0] notes[$];
	logic [91:0] note;
	logic [7:0] b[12];
	logic [2:0] g;
	int num_errors = 0;
	int checked = 0;
	int n, f, i;
	initial forever #20 clock = ~clock;
	scc_init_model i_scc_init_model (.*);
	scc_cdb_checker #(.SUPPORTED(~(256'h1 << 8'h1F)), .PARAM_LIST(256'h1 << 8'h15))
		i_scc_cdb_checker (.*);
	task check(input logic [91:0] seen, input logic [91:0] want);
		checked++;
		if (seen !== want)
		begin
			num_errors++;
			$display("wrong value at %0t: %h expected %h", $time, seen, want);
		end
	endtask
	task finish_test;
		if (num_errors == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	function automatic logic [91:0] exp_of(int n);
		logic [7:0] c;
		logic [2:0] r;
		logic [31:0] x;
		c = b[n - 1];
		x = n == 6 ? (b[4] ? b[4] : 256) : n == 10 ? {b[7], b[8]} : {b[6], b[7], b[8], b[9]};
		if ((g == 3 || g == 4) && !ext_reserved_ok)
			r = 3'h1;
		else if (b[0] == 8'h1F)
			r = 3'h4;
		else if (!ext_reserved_ok && ((g == 1 || g == 2) && b[6] || g == 5 && b[10] || c & 8'h3C))
			r = 3'h2;
		else if (c[1] && !c[0] || !link_supported && c[1:0])
			r = 3'h3;
		else
			r = 3'h0;
		return {r != 0, r, b[0], identify_seen ? identify_lun : b[1][7:5],
			n == 6 ? {11'h0, b[1][4:0], b[2], b[3]} : {b[2], b[3], b[4], b[5]}, x, c, n[3:0],
			r == 0 && b[0] == 8'h15};
	endfunction
	always @(negedge clock)
		if (done_q === 1'b1)
		begin
			note = notes.pop_front();
			check({reject_q, reason_q, opcode_q,
				lun_q, lba_q, xfer_len_q, control_q, cdb_len_q, data_out_q}, note);
			check({accept_q, sense_key_q}, {!note[91], (note[91] ? 4'h5 : 4'h0)});
		end
	initial
	begin
		#200000;
		num_errors++;
		finish_test;
	end
	initial
	begin
		i = $urandom(55877);
		repeat (3) @(posedge clock);
		@(negedge clock) reset_n = 1;
		for (i = 0; i < 64; i++)
		begin
			foreach (b[k]) b[k] = $urandom;
			g = i;
			b[0][7:5] = g;
			if (i < 8)
				b[0][4:0] = 5'h1F;
			else if (i == 8)
				b[0][4:0] = 5'h15;
			n = g == 0 || g == 3 || g == 4 ? 6 : g == 5 ? 12 : 10;
			f = g == 3 || g == 4 || i < 9 ? 0 : $urandom % 4;
			if (g == 1 || g == 2)
				b[6] = f == 1;
			if (g == 5)
				b[1][4:0] = 5'h00;
			if (g == 5)
				b[10] = f == 1;
			b[n - 1][5:0] = {f == 2, 3'h0, f == 3 ? b[n - 1][1:0] : 2'h0};
			ext_reserved_ok = f != 2 && $urandom % 2;
			link_supported = $urandom % 2;
			identify_seen = $urandom % 2;
			identify_lun = $urandom;
			notes.push_back(exp_of(n));
			// an abandoned short block first: the next start must restart the index
			if (i == 9)
				i_scc_init_model.send(b, 3, 0);
			i_scc_init_model.send(b, n, $urandom % 2);
			repeat (2) @(negedge clock);
		end
		check(notes.size(), 0);
		finish_test;
	end
endmodule // scc_cdb_checker_test
